// ### verilog/cpc_regs.svh
// constants for the processor phase clock generator
`ifndef CPC_REGS_SVH
`define CPC_REGS_SVH

`define CPC_OSC_DIV        4
`define CPC_BASIC_NS       90
`define CPC_MICROCYCLE_NS  270
`define CPC_RING_STAGES    (`CPC_MICROCYCLE_NS / `CPC_BASIC_NS)
`define CPC_P0_BIT         0
`define CPC_P1_BIT         1
`define CPC_P2_BIT         2
`define CPC_RING_RESET     3'h1
`define CPC_PEND_DP        0
`define CPC_PEND_SEQ       1
`define CPC_PEND_REG       2

`endif

// ### verilog/cpc_pkg.sv
// types for the processor phase clock generator
package cpc_pkg;

	typedef enum logic [1:0] {
		CPC_MAINT = 2'h0,
		CPC_RUN   = 2'h1,
		CPC_STALL = 2'h3
	} cpc_mode_t;

	typedef struct packed {
		logic memory_request;
		logic cpu_grant;
		logic decode_cycle_flag;
		logic prefetch_wait_enable;
		logic prefetch_not_valid;
		logic data_request;
		logic memory_busy;
	} cpc_mem_status_t;

	typedef struct packed {
		logic ucode_reg_step_request;
		logic upc_step_request;
		logic full_step_request;
	} cpc_step_t;

	typedef struct packed {
		logic ucode_reg_load_clock;
		logic sequencer_clock;
		logic datapath_phase_clock;
	} cpc_phase2_t;

endpackage

// ### verilog/cpc_divider.sv
// divide-by-n tick and square basic clock
`timescale 1ns/1ps
`include "cpc_regs.svh"
module cpc_divider #(
	parameter int DIV = `CPC_OSC_DIV
) (
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic rst_n,
	// outputs
	output logic      tick,
	output logic      basic_clock
);
	localparam int CW = $clog2(DIV);

	logic [CW-1:0] count;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			count <= '0;
		end else if (count == CW'(DIV - 1)) begin
			count <= '0;
		end else begin
			count <= count + CW'(1);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			tick <= 1'b0;
		end else begin
			tick <= (count == CW'(DIV - 1));
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			basic_clock <= 1'b0;
		end else begin
			basic_clock <= (count < CW'(DIV / 2));
		end
	end
endmodule // cpc_divider

// ### verilog/cpc_step_edge.sv
// rising-edge detection of the console step requests
`timescale 1ns/1ps
module cpc_step_edge #(
	parameter int N = 3
) (
	// clock and reset
	input  wire logic         sys_clk,
	input  wire logic         rst_n,
	// requests
	input  wire logic         enable,
	input  wire logic [N-1:0] req,
	// one-cycle pulses
	output logic      [N-1:0] pulse
);
	logic [N-1:0] req_prev;

	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_edge
			always_ff @(posedge sys_clk) begin
				if (!rst_n) begin
					req_prev[i] <= 1'b0;
				end else begin
					req_prev[i] <= req[i];
				end
			end
			assign pulse[i] = enable & req[i] & ~req_prev[i];
		end
	endgenerate
endmodule // cpc_step_edge

// ### verilog/cpc_clock_gen.sv
// processor phase clock generator with run, step and stall gating
`timescale 1ns/1ps
`include "cpc_regs.svh"
module cpc_clock_gen
	import cpc_pkg::*;
#(
	parameter int OSC_DIV = `CPC_OSC_DIV
) (
	// clock and reset
	input  wire logic            sys_clk,
	input  wire logic            rst_n,
	// console control
	input  wire logic            cpu_run,
	input  wire cpc_step_t       step_req,
	// stall sources
	input  wire logic            store_refresh_request,
	input  wire logic            cs_parity_error,
	input  wire cpc_mem_status_t mem_status,
	// free-running clocks
	output logic                 basic_clock,
	output logic                 phase_zero_clock,
	output logic                 phase_one_clock,
	// gated third-phase clocks
	output cpc_phase2_t          phase2,
	// status
	output logic                 clock_stall,
	output logic                 maint_mode,
	output logic                 parity_interrupt
);

	logic        tick;
	logic [2:0]  ring;
	logic [2:0]  step_pulse;
	logic [2:0]  pend;
	logic [2:0]  next_pend;
	logic [2:0]  fire;
	logic        refr_prev;
	logic        refr_pend;
	logic        slot;
	logic        mem_stall;
	logic        hard_stall;
	cpc_mode_t   mode;
	cpc_mode_t   next_mode;

	// basic clock divider
	cpc_divider #(
		.DIV         (OSC_DIV)
	) u_div (
		.sys_clk     (sys_clk),
		.rst_n       (rst_n),
		.tick        (tick),
		.basic_clock (basic_clock)
	);

	// step request edges, only while run is low
	cpc_step_edge #(
		.N       (3)
	) u_step (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.enable  (~cpu_run),
		.req     (step_req),
		.pulse   (step_pulse)
	);

	// three-stage ring, advances once per basic clock
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			ring <= `CPC_RING_RESET;
		end else if (tick) begin
			ring <= {ring[1:0], ring[2]};
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			phase_zero_clock <= 1'b0;
			phase_one_clock  <= 1'b0;
		end else begin
			phase_zero_clock <= ring[`CPC_P0_BIT];
			phase_one_clock  <= ring[`CPC_P1_BIT];
		end
	end

	// a phase-two slot opens on the tick that leaves phase one
	assign slot = tick & ring[`CPC_P1_BIT];

	// memory interaction stalls
	always_comb begin
		mem_stall = 1'b0;
		if (mem_status.memory_request && !mem_status.cpu_grant) begin
			mem_stall = 1'b1;
		end
		if (mem_status.decode_cycle_flag
			&& !mem_status.memory_request
			&& mem_status.prefetch_wait_enable
			&& mem_status.prefetch_not_valid
			&& mem_status.memory_busy) begin
			mem_stall = 1'b1;
		end
		if (mem_status.data_request && mem_status.memory_busy) begin
			mem_stall = 1'b1;
		end
	end

	assign hard_stall = cs_parity_error | mem_stall;

	// refresh request caught on its rising edge, spent at one slot
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			refr_prev <= 1'b0;
		end else begin
			refr_prev <= store_refresh_request;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			refr_pend <= 1'b0;
		end else if (store_refresh_request && !refr_prev) begin
			refr_pend <= 1'b1;
		end else if (slot) begin
			refr_pend <= 1'b0;
		end
	end

	// which third-phase clocks fire at this slot
	always_comb begin
		fire = 3'h0;
		if (cpu_run) begin
			if (!refr_pend && !hard_stall) begin
				fire = 3'h7;
			end
		end else if (!refr_pend) begin
			fire[`CPC_PEND_SEQ] = pend[`CPC_PEND_SEQ];
			fire[`CPC_PEND_REG] = pend[`CPC_PEND_REG];
			fire[`CPC_PEND_DP]  = pend[`CPC_PEND_DP] & ~hard_stall;
		end
	end

	// pending steps: new requests win over a clear in the same cycle
	always_comb begin
		next_pend = pend;
		if (slot) begin
			next_pend = pend & ~fire;
		end
		if (step_pulse[0]) begin
			next_pend = 3'h7;
		end
		if (step_pulse[1]) begin
			next_pend[`CPC_PEND_SEQ] = 1'b1;
		end
		if (step_pulse[2]) begin
			next_pend[`CPC_PEND_REG] = 1'b1;
		end
		if (cpu_run) begin
			next_pend = 3'h0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pend <= 3'h0;
		end else begin
			pend <= next_pend;
		end
	end

	// gated third-phase outputs, held for the whole third stage
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			phase2 <= '0;
		end else if (slot) begin
			phase2.datapath_phase_clock <= fire[`CPC_PEND_DP];
			phase2.sequencer_clock      <= fire[`CPC_PEND_SEQ];
			phase2.ucode_reg_load_clock <= fire[`CPC_PEND_REG];
		end else if (tick) begin
			phase2 <= '0;
		end
	end

	// operating mode
	always_comb begin
		case (mode)
			CPC_MAINT: next_mode = cpu_run ? CPC_RUN : CPC_MAINT;
			CPC_RUN: begin
				if (!cpu_run) begin
					next_mode = CPC_MAINT;
				end else if (hard_stall || refr_pend) begin
					next_mode = CPC_STALL;
				end else begin
					next_mode = CPC_RUN;
				end
			end
			CPC_STALL: begin
				if (!cpu_run) begin
					next_mode = CPC_MAINT;
				end else if (!hard_stall && !refr_pend) begin
					next_mode = CPC_RUN;
				end else begin
					next_mode = CPC_STALL;
				end
			end
			default: next_mode = CPC_MAINT;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			mode <= CPC_MAINT;
		end else begin
			mode <= next_mode;
		end
	end

	assign maint_mode = (mode == CPC_MAINT);

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			clock_stall      <= 1'b0;
			parity_interrupt <= 1'b0;
		end else begin
			clock_stall      <= hard_stall;
			parity_interrupt <= cs_parity_error;
		end
	end

	// checks
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	a_div_period: assert property (
		tick |=> !tick [*3] ##1 tick
	) else $error("basic clock tick spacing wrong");

	a_ring_onehot: assert property (
		$onehot(ring)
	) else $error("ring not one-hot");

	a_p1_follows: assert property (
		tick && ring[`CPC_P0_BIT] |=> ##1 phase_one_clock
	) else $error("phase one did not follow phase zero");

	a_run_fires: assert property (
		slot && cpu_run && !refr_pend && !hard_stall
		|=> phase2 == 3'h7
	) else $error("run slot did not fire all clocks");

	a_maint_gate: assert property (
		$rose(phase2.datapath_phase_clock)
		|-> $past(cpu_run) || $past(pend[`CPC_PEND_DP])
	) else $error("datapath clock fired in maintenance without a step");

	a_run_no_pend: assert property (
		cpu_run |=> pend == 3'h0
	) else $error("step pending while running");

	a_full_step: assert property (
		slot && !cpu_run && pend == 3'h7 && !refr_pend && !hard_stall
		|=> phase2 == 3'h7 ##1 pend == 3'h0
	) else $error("full step did not pulse all three");

	a_upc_only: assert property (
		slot && !cpu_run && pend == 3'h2 && !refr_pend
		|=> phase2 == 3'h2
	) else $error("sequencer step pulsed other clocks");

	a_reg_only: assert property (
		slot && !cpu_run && pend == 3'h4 && !refr_pend
		|=> phase2 == 3'h4
	) else $error("register step pulsed other clocks");

	a_refresh_gap: assert property (
		slot && refr_pend |=> (phase2 == 3'h0) [*4] ##1 !refr_pend
	) else $error("refresh did not suppress one microcycle");

	a_parity_irq: assert property (
		cs_parity_error |=> parity_interrupt && clock_stall
	) else $error("parity error not flagged");

	a_dp_stalled: assert property (
		slot && hard_stall |=> !phase2.datapath_phase_clock
	) else $error("datapath clock fired during stall");

	a_step_catch: assert property (
		!cpu_run && step_pulse[1] |=> pend[`CPC_PEND_SEQ]
	) else $error("sequencer step not captured");

	a_p2_in_stage: assert property (
		phase2 != 3'h0 |-> ring[`CPC_P2_BIT]
	) else $error("third-phase clock outside the third stage");

	a_phase_excl: assert property (
		!(phase_zero_clock && phase_one_clock)
	) else $error("phase zero and phase one overlap");

	a_stop_maint: assert property (
		!cpu_run |=> maint_mode
	) else $error("run low did not enter maintenance");

	a_stall_mode: assert property (
		mode != CPC_MAINT && cpu_run && hard_stall |=> mode == CPC_STALL
	) else $error("stall not reflected in mode");

	a_grant_stall: assert property (
		slot && cpu_run && mem_status.memory_request
		&& !mem_status.cpu_grant |=> phase2 == 3'h0
	) else $error("clocks ran without memory grant");

	a_prefetch_stall: assert property (
		mem_status.decode_cycle_flag
		&& !mem_status.memory_request
		&& mem_status.prefetch_wait_enable
		&& mem_status.prefetch_not_valid
		&& mem_status.memory_busy |=> clock_stall
	) else $error("prefetch wait did not stall");

	a_busy_stall: assert property (
		mem_status.data_request && mem_status.memory_busy |=> clock_stall
	) else $error("busy data transfer did not stall");

	a_maint_refresh: assert property (
		slot && !cpu_run && refr_pend |=> phase2 == 3'h0
	) else $error("refresh did not delay stepped clocks");

	c_run_slot: cover property (slot && cpu_run && !hard_stall);
	c_full_step: cover property (step_pulse[0] ##[1:20] phase2 == 3'h7);
	c_step_stall: cover property (slot && !cpu_run && hard_stall && pend[1]);
	c_refresh: cover property (slot && refr_pend && cpu_run);

endmodule // cpc_clock_gen

// ### sim/cpc_mem_model.sv
// memory controller stand-in: busy for a set delay, grant after it
`timescale 1ns/1ps
module cpc_mem_model
	import cpc_pkg::*;
(
	// clock and reset
	input  wire logic            sys_clk,
	input  wire logic            rst_n,
	// bench commands
	input  wire cpc_mem_status_t cmd,
	input  wire logic            start,
	input  wire logic [7:0]      wait_cycles,
	input  wire logic            hard_error,
	// toward the clock generator
	output cpc_mem_status_t      mem_status
);
	logic [7:0] cnt;

	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			cnt <= 8'h00;
		else if (start)
			cnt <= wait_cycles;
		else if (cnt != 8'h00)
			cnt <= cnt - 8'h01;
	end

	always_comb begin
		mem_status = cmd;
		mem_status.cpu_grant = (cnt == 8'h00);
		// a hard error drops busy at once so no busy stall can hang; the grant stall still waits out the count
		mem_status.memory_busy = (cnt != 8'h00) && !hard_error;
	end
endmodule // cpc_mem_model

// ### sim/cpc_clock_gen_tb_top.sv
// self-checking bench for the phase clock generator
`timescale 1ns/1ps
module cpc_clock_gen_tb_top
	import cpc_pkg::*;
;
	logic            sys_clk;
	logic            rst_n;
	logic            cpu_run;
	cpc_step_t       step_req;
	logic            refresh;
	logic            parity;
	cpc_mem_status_t cmd;
	logic            start;
	logic [7:0]      wait_cycles;
	logic            hard_err;
	cpc_mem_status_t mem_status;
	logic            basic_clock;
	logic            p0;
	logic            p1;
	cpc_phase2_t     phase2;
	logic            clock_stall;
	logic            maint_mode;
	logic            parity_interrupt;
	logic [5:0]      prev;
	logic [47:0]     cnt;
	logic [47:0]     snap;
	int              bad_count;
	int              tests_run;
	wire  [5:0]      sig = {phase2, p1, p0, basic_clock};
	localparam logic [6:0] stall_cfg [3] = '{7'h40, 7'h1C, 7'h02};

	cpc_clock_gen i_dut (
		.sys_clk              (sys_clk),
		.rst_n                (rst_n),
		.cpu_run              (cpu_run),
		.step_req             (step_req),
		.store_refresh_request(refresh),
		.cs_parity_error      (parity),
		.mem_status           (mem_status),
		.basic_clock          (basic_clock),
		.phase_zero_clock     (p0),
		.phase_one_clock      (p1),
		.phase2               (phase2),
		.clock_stall          (clock_stall),
		.maint_mode           (maint_mode),
		.parity_interrupt     (parity_interrupt)
	);

	cpc_mem_model i_mem (
		.sys_clk    (sys_clk),
		.rst_n      (rst_n),
		.cmd        (cmd),
		.start      (start),
		.wait_cycles(wait_cycles),
		.hard_error (hard_err),
		.mem_status (mem_status)
	);

	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	// rising edges of every clock output
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			prev <= '0;
			cnt  <= '0;
		end else begin
			prev <= sig;
			for (int i = 0; i < 6; i++)
				if (sig[i] && !prev[i])
					cnt[8*i +: 8] <= cnt[8*i +: 8] + 8'h01;
		end
	end

	task automatic end_sim();
		if (bad_count == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk_cnt(input logic [47:0] got, input logic [47:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	// counts over n cycles; free clocks expected from n
	task automatic win(input int n, input logic [23:0] exp);
		logic [47:0] d;
		#1;
		snap = cnt;
		repeat (n) @(posedge sys_clk);
		#1;
		for (int i = 0; i < 6; i++)
			d[8*i +: 8] = cnt[8*i +: 8] - snap[8*i +: 8];
		chk_cnt(d, {exp, 8'(n / 12), 8'(n / 12), 8'(n / 4)});
	endtask

	task automatic step(input logic [2:0] v);
		@(posedge sys_clk);
		step_req <= cpc_step_t'(v);
		@(posedge sys_clk);
		step_req <= cpc_step_t'(3'h0);
	endtask

	initial begin
		repeat (4000) @(posedge sys_clk);
		bad_count++;
		end_sim();
	end

	initial begin
		rst_n = 1'b0;
		cpu_run = 1'b0;
		step_req = '0;
		refresh = 1'b0;
		parity = 1'b0;
		cmd = '0;
		start = 1'b0;
		wait_cycles = 8'h00;
		hard_err = 1'b0;
		bad_count = 0;
		tests_run = 0;
		idle(12);
		rst_n <= 1'b1;
		win(36, 24'h0);
		chk_bit(maint_mode, 1'b1);
		for (int i = 0; i < 3; i++) begin
			step(3'h1 << i);
			win(36, (i == 0) ? 24'h010101 : 24'h1 << (8 * i));
		end
		// a request held high over several slots steps only once
		@(posedge sys_clk);
		step_req <= cpc_step_t'(3'h2);
		win(36, 24'h000100);
		step_req <= cpc_step_t'(3'h0);
		// refresh together with a step delays it one microcycle
		@(posedge sys_clk);
		refresh <= 1'b1;
		step_req <= cpc_step_t'(3'h1);
		@(posedge sys_clk);
		refresh <= 1'b0;
		step_req <= cpc_step_t'(3'h0);
		win(12, 24'h0);
		win(24, 24'h010101);
		@(posedge sys_clk);
		parity <= 1'b1;
		step(3'h1);
		win(36, 24'h010100);
		@(posedge sys_clk);
		parity <= 1'b0;
		win(36, 24'h000001);
		@(posedge sys_clk);
		cpu_run <= 1'b1;
		idle(12);
		chk_bit(maint_mode, 1'b0);
		win(120, 24'h0A0A0A);
		@(posedge sys_clk);
		refresh <= 1'b1;
		@(posedge sys_clk);
		refresh <= 1'b0;
		win(120, 24'h090909);
		step(3'h1);
		@(posedge sys_clk);
		cpu_run <= 1'b0;
		idle(12);
		win(36, 24'h0);
		@(posedge sys_clk);
		cpu_run <= 1'b1;
		parity <= 1'b1;
		idle(2);
		win(36, 24'h0);
		chk_bit(clock_stall, 1'b1);
		chk_bit(parity_interrupt, 1'b1);
		@(posedge sys_clk);
		parity <= 1'b0;
		idle(12);
		win(36, 24'h030303);
		for (int i = 0; i < 3; i++) begin
			@(posedge sys_clk);
			cmd <= cpc_mem_status_t'(stall_cfg[i]);
			start <= 1'b1;
			wait_cycles <= (i == 2) ? 8'hFF : 8'h3C;
			@(posedge sys_clk);
			start <= 1'b0;
			idle(2);
			win(36, 24'h0);
			chk_bit(clock_stall, 1'b1);
			if (i == 2)
				hard_err <= 1'b1;
			idle(24);
			win(36, 24'h030303);
		end
		end_sim();
	end
endmodule // cpc_clock_gen_tb_top
